// ===== rtl/fsr_pkg.sv
package fsr_pkg;
  // ****************
  // Opcodes
  // ****************
  localparam logic [7:0] FSR_OP_READ_ONE   = 8'h05;
  localparam logic [7:0] FSR_OP_READ_TWO   = 8'h35;
  localparam logic [7:0] FSR_OP_READ_THREE = 8'h15;
  // ****************
  // Field positions
  // ****************
  localparam int FSR_S1_PROT_LO  = 7;
  localparam int FSR_S1_BP_HI    = 6;
  localparam int FSR_S1_BP_LO    = 2;
  localparam int FSR_S1_WEL      = 1;
  localparam int FSR_S1_BUSY     = 0;
  localparam int FSR_S2_ERS_PAUSE = 7;
  localparam int FSR_S2_INVERT   = 6;
  localparam int FSR_S2_LOCK_HI  = 5;
  localparam int FSR_S2_LOCK_LO  = 3;
  localparam int FSR_S2_PRG_PAUSE = 2;
  localparam int FSR_S2_QUAD     = 1;
  localparam int FSR_S2_PROT_HI  = 0;
  localparam int FSR_S3_DRV_HI   = 6;
  localparam int FSR_S3_DRV_LO   = 5;
  // ****************
  // Writable masks and resets
  // ****************
  localparam logic [7:0] FSR_S1_WR_MASK = 8'hFC;
  localparam logic [7:0] FSR_S2_WR_MASK = 8'h7B;
  localparam logic [7:0] FSR_S3_WR_MASK = 8'h60;
  localparam logic [7:0] FSR_S1_RESET   = 8'h00;
  localparam logic [7:0] FSR_S2_RESET   = 8'h00;
  localparam logic [7:0] FSR_S3_RESET   = 8'h60;
  localparam logic [1:0] FSR_DRV_AUTO   = 2'h3;
  localparam logic [1:0] FSR_DRV_HALF   = 2'h2;
  localparam logic [1:0] FSR_DRV_3Q     = 2'h1;
  localparam logic [1:0] FSR_DRV_FULL   = 2'h0;
  // ****************
  // Write selects and counters
  // ****************
  localparam logic [1:0] FSR_SEL_ONE   = 2'h1;
  localparam logic [1:0] FSR_SEL_TWO   = 2'h2;
  localparam logic [1:0] FSR_SEL_THREE = 2'h3;
  localparam logic [2:0] FSR_BIT_TOP   = 3'h7;
  localparam logic [2:0] FSR_BIT_ZERO  = 3'h0;
  localparam logic [3:0] FSR_OP_BITS   = 4'h8;

  typedef enum logic [3:0] {
    FSR_IDLE   = 4'b0001,
    FSR_OPCODE = 4'b0010,
    FSR_SHIFT  = 4'b0100,
    FSR_IGNORE = 4'b1000
  } fsr_state_type;
endpackage

// ===== rtl/fsr_status_read.sv
`timescale 1ns/1ps
module fsr_status_read
(
  // ****************
  // Clock and reset
  // ****************
  input  wire logic       clock,
  input  wire logic       rst,
  // ****************
  // Serial pins
  // ****************
  input  wire logic       sclk_pin,
  input  wire logic       cs_n_pin,
  input  wire logic       serial_in_pin,
  output logic            serial_out_pin,
  output logic            serial_out_oe,
  // ****************
  // Device state from engines
  // ****************
  input  wire logic       busy_in,
  input  wire logic       wel_set,
  input  wire logic       wel_clr,
  input  wire logic       dev_reset_op,
  input  wire logic       erase_paused_in,
  input  wire logic       program_paused_in,
  // ****************
  // Write status path
  // ****************
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_sel,
  input  wire logic [7:0] wr_data,
  // ****************
  // Control outputs
  // ****************
  output logic [2:0]      page_lock,
  output logic            quad_io_enable,
  output logic [1:0]      output_strength_sel,
  output logic            write_latch_flag
);
  import fsr_pkg::*;

  // ****************
  // Pin synchronisers
  // ****************
  logic [1:0] sclk_s_r;
  logic [1:0] cs_s_r;
  logic [1:0] si_s_r;
  logic       sclk_d_r;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_act;

  // Stage one feeds stage two only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_s_r <= 2'h0;
      cs_s_r   <= 2'h3;
      si_s_r   <= 2'h0;
      sclk_d_r <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], sclk_pin};
      cs_s_r   <= {cs_s_r[0], cs_n_pin};
      si_s_r   <= {si_s_r[0], serial_in_pin};
      sclk_d_r <= sclk_s_r[1];
    end
  end

  assign sclk_rise = sclk_s_r[1] & ~sclk_d_r;
  assign sclk_fall = ~sclk_s_r[1] & sclk_d_r;
  assign cs_act    = ~cs_s_r[1];

  // ****************
  // Status registers
  // ****************
  logic [7:0] s1_r;
  logic [7:0] s2_r;
  logic [7:0] s3_r;
  logic       wel_r;
  logic [7:0] live_one;
  logic [7:0] live_two;
  logic [7:0] live_three;

  // Set beats an engine clear; device reset clears outright
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wel_r <= 1'b0;
    end else if (dev_reset_op) begin
      wel_r <= 1'b0;
    end else if (wel_set) begin
      wel_r <= 1'b1;
    end else if (wel_clr) begin
      wel_r <= 1'b0;
    end
  end

  // Only writable bits are stored; the rest read from hardware, or as zero in register three
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_r <= FSR_S1_RESET;
      s2_r <= FSR_S2_RESET;
      s3_r <= FSR_S3_RESET;
    end else if (wr_en) begin
      case (wr_sel)
        FSR_SEL_ONE: begin
          s1_r <= wr_data & FSR_S1_WR_MASK;
        end
        FSR_SEL_TWO: begin
          s2_r <= wr_data & FSR_S2_WR_MASK;
        end
        FSR_SEL_THREE: begin
          s3_r <= wr_data & FSR_S3_WR_MASK;
        end
        default: begin
          s1_r <= s1_r;
        end
      endcase
    end
  end

  always_comb begin
    live_one = s1_r;
    live_one[FSR_S1_WEL]  = wel_r;
    live_one[FSR_S1_BUSY] = busy_in;
    live_two = s2_r;
    live_two[FSR_S2_ERS_PAUSE] = erase_paused_in;
    live_two[FSR_S2_PRG_PAUSE] = program_paused_in;
    live_three = s3_r & FSR_S3_WR_MASK;
  end

  assign page_lock           = s2_r[FSR_S2_LOCK_HI:FSR_S2_LOCK_LO];
  assign quad_io_enable      = s2_r[FSR_S2_QUAD];
  assign output_strength_sel = s3_r[FSR_S3_DRV_HI:FSR_S3_DRV_LO];
  assign write_latch_flag    = wel_r;

  // ****************
  // Serial state machine
  // ****************
  fsr_state_type state_r;
  fsr_state_type state_nxt;
  logic [7:0]    op_r;
  logic [3:0]    op_cnt_r;
  logic [1:0]    sel_r;
  logic [2:0]    idx_r;
  logic [7:0]    snap_r;
  logic [7:0]    op_full;
  logic [7:0]    live_sel;

  assign op_full = {op_r[6:0], si_s_r[1]};

  // No busy gating: reads run during program or erase
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FSR_IDLE: begin
        if (cs_act) begin
          state_nxt = FSR_OPCODE;
        end
      end
      FSR_OPCODE: begin
        if (sclk_rise && op_cnt_r == FSR_OP_BITS - 4'h1) begin
          if (op_full == FSR_OP_READ_ONE || op_full == FSR_OP_READ_TWO ||
              op_full == FSR_OP_READ_THREE) begin
            state_nxt = FSR_SHIFT;
          end else begin
            state_nxt = FSR_IGNORE;
          end
        end
      end
      FSR_SHIFT: begin
        state_nxt = FSR_SHIFT;
      end
      FSR_IGNORE: begin
        state_nxt = FSR_IGNORE;
      end
      default: begin
        state_nxt = FSR_IDLE;
      end
    endcase
    if (!cs_act) begin
      state_nxt = FSR_IDLE;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= FSR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Opcode capture, MSB first on rising edges
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      op_r     <= 8'h00;
      op_cnt_r <= 4'h0;
      sel_r    <= FSR_SEL_ONE;
    end else if (!cs_act) begin
      op_cnt_r <= 4'h0;
    end else if (state_r == FSR_OPCODE && sclk_rise) begin
      op_r     <= op_full;
      op_cnt_r <= op_cnt_r + 4'h1;
      case (op_full)
        FSR_OP_READ_ONE: begin
          sel_r <= FSR_SEL_ONE;
        end
        FSR_OP_READ_TWO: begin
          sel_r <= FSR_SEL_TWO;
        end
        FSR_OP_READ_THREE: begin
          sel_r <= FSR_SEL_THREE;
        end
        default: begin
          sel_r <= sel_r;
        end
      endcase
    end
  end

  always_comb begin
    case (sel_r)
      FSR_SEL_TWO: begin
        live_sel = live_two;
      end
      FSR_SEL_THREE: begin
        live_sel = live_three;
      end
      default: begin
        live_sel = live_one;
      end
    endcase
  end

  // Fresh snapshot at every bit 7 so polling sees busy drop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      idx_r          <= FSR_BIT_TOP;
      snap_r         <= 8'h00;
      serial_out_pin <= 1'b0;
    end else if (state_r != FSR_SHIFT) begin
      idx_r <= FSR_BIT_TOP;
    end else if (sclk_fall) begin
      if (idx_r == FSR_BIT_TOP) begin
        snap_r         <= live_sel;
        serial_out_pin <= live_sel[FSR_BIT_TOP];
      end else begin
        serial_out_pin <= snap_r[idx_r];
      end
      idx_r <= idx_r - 3'h1;
    end
  end

  // Enable follows select directly; mid-byte rise releases the pin
  assign serial_out_oe = (state_r == FSR_SHIFT) && cs_act;

  // ****************
  // Assertions
  // ****************
  logic sel_one_seen;
  assign sel_one_seen = state_r == FSR_SHIFT && sel_r == FSR_SEL_ONE;

  property p_cs_release;
    @(posedge clock) disable iff (rst)
      !cs_s_r[1] ##1 cs_s_r[1] |-> !serial_out_oe ##1 (state_r == FSR_IDLE && !serial_out_oe);
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("Out enable after select rise");
  property p_first_bit;
    @(posedge clock) disable iff (rst)
      (state_r == FSR_SHIFT && sclk_fall && idx_r == FSR_BIT_TOP) |=> serial_out_pin == $past(live_sel[FSR_BIT_TOP]);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("Bit 7 not sent first");
  property p_snap_live;
    @(posedge clock) disable iff (rst)
      (state_r == FSR_SHIFT && sclk_fall && idx_r == FSR_BIT_TOP) |=> snap_r == $past(live_sel);
  endproperty
  a_snap_live: assert property (p_snap_live) else $error("Snapshot not live");
  property p_wrap;
    @(posedge clock) disable iff (rst)
      (state_r == FSR_SHIFT && sclk_fall && idx_r == FSR_BIT_ZERO && cs_act) |=> idx_r == FSR_BIT_TOP;
  endproperty
  a_wrap: assert property (p_wrap) else $error("No wrap to bit 7");
  property p_wel_reset;
    @(posedge clock) disable iff (rst) dev_reset_op |=> !write_latch_flag;
  endproperty
  a_wel_reset: assert property (p_wel_reset) else $error("Latch kept after reset");
  property p_ro_bits;
    @(posedge clock) disable iff (rst)
      (wr_en && !wel_set && !wel_clr && !dev_reset_op) |=> write_latch_flag == $past(write_latch_flag);
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("Read-only bit written");
  property p_reserved;
    @(posedge clock) disable iff (rst) (s3_r & ~FSR_S3_WR_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bit nonzero");
  property p_quad_write;
    @(posedge clock) disable iff (rst)
      (wr_en && wr_sel == FSR_SEL_TWO) |=> quad_io_enable == $past(wr_data[FSR_S2_QUAD]);
  endproperty
  a_quad_write: assert property (p_quad_write) else $error("Quad bit not stored");
  property p_bad_op;
    @(posedge clock) disable iff (rst) state_r == FSR_IGNORE |-> !serial_out_oe;
  endproperty
  a_bad_op: assert property (p_bad_op) else $error("Drive on unknown opcode");
  property p_busy_read;
    @(posedge clock) disable iff (rst) busy_in |-> live_one[FSR_S1_BUSY];
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("Busy not shown");

  c_read_one: cover property (@(posedge clock) disable iff (rst) sel_one_seen && sclk_fall);
  c_read_two: cover property (@(posedge clock) disable iff (rst) state_r == FSR_SHIFT && sel_r == FSR_SEL_TWO);
  c_read_three: cover property (@(posedge clock) disable iff (rst) state_r == FSR_SHIFT && sel_r == FSR_SEL_THREE);
  c_mid_abort: cover property (@(posedge clock) disable iff (rst)
    state_r == FSR_SHIFT && idx_r == 3'h3 ##1 !cs_act);
endmodule

// ===== verif/fsr_host_model.sv
`timescale 1ns/1ps
module fsr_host_model (
  // Clock
  input  wire logic clock,
  // Serial pins
  output logic      sclk_pin,
  output logic      cs_n_pin,
  output logic      serial_in_pin,
  input  wire logic serial_out_pin,
  input  wire logic serial_out_oe
);
  logic so_line;
  // Floating line reads as the inverse of the last bit, never stale
  assign so_line = serial_out_oe ? serial_out_pin : ~serial_out_pin;
  initial begin
    sclk_pin      = 1'b0;
    cs_n_pin      = 1'b1;
    serial_in_pin = 1'b0;
  end
  // Half period of 4 clocks keeps edges clear of the sync chain
  task automatic half();
    repeat (4) @(posedge clock);
  endtask
  task automatic xfer(input logic [7:0] op, input int nbits, output logic [15:0] rx,
                      output logic oe_mid, output logic oe_end);
    rx = '0;
    oe_mid = 1'b0;
    cs_n_pin <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      serial_in_pin <= op[i];
      half();
      sclk_pin <= 1'b1;
      half();
      sclk_pin <= 1'b0;
    end
    // Released data line shows inverse, never a stale value
    serial_in_pin <= ~op[0];
    for (int i = 0; i < nbits; i++) begin
      half();
      rx = {rx[14:0], so_line};
      if (i == 0) oe_mid = serial_out_oe;
      sclk_pin <= 1'b1;
      half();
      sclk_pin <= 1'b0;
    end
    half();
    cs_n_pin <= 1'b1;
    half();
    half();
    oe_end = serial_out_oe;
  endtask
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import fsr_pkg::*;
  // ****************
  // Signals
  // ****************
  logic        clock, rst, sclk_pin, cs_n_pin, serial_in_pin, serial_out_pin, serial_out_oe;
  logic        busy_in, wel_set, wel_clr, dev_reset_op, erase_paused_in, program_paused_in;
  logic        wr_en, quad_io_enable, write_latch_flag, oe_mid, oe_end;
  logic [1:0]  wr_sel, output_strength_sel;
  logic [2:0]  page_lock;
  logic [7:0]  wr_data;
  logic [15:0] rx;
  int          fails, check_count;

  fsr_status_read dut_u (.clock(clock), .rst(rst), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .busy_in(busy_in), .wel_set(wel_set), .wel_clr(wel_clr), .dev_reset_op(dev_reset_op),
    .erase_paused_in(erase_paused_in), .program_paused_in(program_paused_in), .wr_en(wr_en),
    .wr_sel(wr_sel), .wr_data(wr_data), .page_lock(page_lock), .quad_io_enable(quad_io_enable),
    .output_strength_sel(output_strength_sel), .write_latch_flag(write_latch_flag));
  fsr_host_model host_u (.clock(clock), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ****************
  // Tasks
  // ****************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] sel, input logic [7:0] data);
    @(posedge clock);
    wr_en   <= 1'b1;
    wr_sel  <= sel;
    wr_data <= data;
    @(posedge clock);
    wr_en <= 1'b0;
    @(posedge clock);
  endtask
  // Data is compared only when a reply is expected
  task automatic rd(input logic [7:0] op, input int n, input logic [15:0] exp, input logic drv);
    host_u.xfer(op, n, rx, oe_mid, oe_end);
    if (drv) chk("status data", exp, rx);
    chk("drive during reply", 16'(drv), 16'(oe_mid));
    chk("drive after select", 16'h0000, 16'(oe_end));
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    complete_run();
  end
  // ****************
  // Tests
  // ****************
  initial begin
    fails = 0;
    check_count = 0;
    rst = 1'b1;
    {busy_in, wel_set, wel_clr, dev_reset_op, erase_paused_in, program_paused_in} = 6'h00;
    wr_en = 1'b0;
    wr_sel = 2'h0;
    wr_data = 8'h00;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    chk("strength", 16'h0003, 16'(output_strength_sel));
    chk("locks quad latch", 16'h0000, 16'({page_lock, quad_io_enable, write_latch_flag}));
    rd(FSR_OP_READ_THREE, 8, 16'h0060, 1'b1);
    busy_in <= 1'b1;
    erase_paused_in <= 1'b1;
    program_paused_in <= 1'b1;
    wr(FSR_SEL_ONE, 8'hFF);
    wr(FSR_SEL_TWO, 8'hFF);
    wel_set <= 1'b1;
    @(posedge clock);
    wel_set <= 1'b0;
    @(posedge clock);
    rd(FSR_OP_READ_ONE, 16, 16'hFFFF, 1'b1);
    rd(FSR_OP_READ_TWO, 8, 16'h00FF, 1'b1);
    chk("locks quad", 16'h000F, 16'({page_lock, quad_io_enable}));
    dev_reset_op <= 1'b1;
    @(posedge clock);
    dev_reset_op <= 1'b0;
    repeat (2) @(posedge clock);
    chk("latch", 16'h0000, 16'(write_latch_flag));
    // Set and clear together: set wins
    {wel_set, wel_clr} <= 2'h3;
    @(posedge clock);
    {wel_set, wel_clr} <= 2'h0;
    repeat (2) @(posedge clock);
    chk("latch set wins", 16'h0001, 16'(write_latch_flag));
    wel_clr <= 1'b1;
    @(posedge clock);
    wel_clr <= 1'b0;
    repeat (2) @(posedge clock);
    chk("latch clear", 16'h0000, 16'(write_latch_flag));
    wr(FSR_SEL_ONE, 8'h00);
    wr(FSR_SEL_TWO, 8'h00);
    rd(FSR_OP_READ_ONE, 8, 16'h0001, 1'b1);
    rd(FSR_OP_READ_TWO, 8, 16'h0084, 1'b1);
    {busy_in, erase_paused_in, program_paused_in} <= 3'h0;
    @(posedge clock);
    // Busy rises mid-byte, so only the repeat may show it
    fork
      rd(FSR_OP_READ_ONE, 16, 16'h0001, 1'b1);
      begin
        repeat (100) @(posedge clock);
        busy_in <= 1'b1;
      end
    join
    for (int i = 0; i < 4; i++) begin
      wr(FSR_SEL_THREE, {1'b1, i[1:0], 5'h1F});
      chk("strength", 16'(i), 16'(output_strength_sel));
      rd(FSR_OP_READ_THREE, 8, 16'({i[1:0], 5'h00}), 1'b1);
    end
    rd(FSR_OP_READ_ONE, 3, 16'h0000, 1'b1);
    rd(8'h9F, 8, 16'h0000, 1'b0);
    complete_run();
  end
endmodule
